/* File: rtl/ifw_pkg.sv */
// Constants for the identification feature word block
package ifw_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int IFW_ADDR_W = 12;
    localparam int IFW_DATA_W = 32;
    localparam int IFW_WORD_W = 16;
    localparam int IFW_STRB_W = 4;
    localparam int IFW_BYTE_W = 8;

    // ------------------------------------------------------------
    // Identification word indices; byte address is four times these
    // ------------------------------------------------------------
    localparam logic [IFW_ADDR_W-1:0] IFW_IDX_SUPPORT_EXT = 12'h054;
    localparam logic [IFW_ADDR_W-1:0] IFW_IDX_ENABLED_ONE = 12'h055;
    localparam logic [IFW_ADDR_W-1:0] IFW_IDX_ENABLED_TWO = 12'h056;
    localparam logic [IFW_ADDR_W-1:0] IFW_IDX_DEFAULT = 12'h057;
    localparam logic [IFW_ADDR_W-1:0] IFW_IDX_UDMA_MODE = 12'h058;
    localparam int IFW_IDX_SHIFT = 2;

    // ------------------------------------------------------------
    // Control and status registers, byte addresses
    // ------------------------------------------------------------
    localparam logic [IFW_ADDR_W-1:0] IFW_ADDR_CTRL_ONE = 12'h000;
    localparam logic [IFW_ADDR_W-1:0] IFW_ADDR_CTRL_TWO = 12'h004;
    localparam logic [IFW_ADDR_W-1:0] IFW_ADDR_UDMA_SEL = 12'h008;
    localparam logic [IFW_ADDR_W-1:0] IFW_ADDR_STATUS = 12'h00C;

    // ------------------------------------------------------------
    // Fixed words: bit 15 zero, bit 14 one, rest reserved
    // ------------------------------------------------------------
    localparam logic [IFW_WORD_W-1:0] IFW_EXT_WORD_VALUE = 16'h4000;
    localparam logic [IFW_WORD_W-1:0] IFW_DEFAULT_WORD_VALUE = 16'h4000;

    // ------------------------------------------------------------
    // Enabled word one: writable enables (14,13,12,10..5,3..0)
    // Bits 15 and 11 obsolete and bit 4 always zero
    // ------------------------------------------------------------
    localparam logic [IFW_WORD_W-1:0] IFW_ONE_MASK = 16'h77EF;
    localparam logic [IFW_WORD_W-1:0] IFW_ONE_RESET = 16'h0000;
    localparam int IFW_ONE_LOOK_AHEAD = 6;
    localparam int IFW_ONE_WRITE_CACHE = 5;

    // ------------------------------------------------------------
    // Enabled word two: writable enables (9,5,4,3,2) and fixed bits
    // ------------------------------------------------------------
    localparam logic [IFW_WORD_W-1:0] IFW_TWO_MASK = 16'h023C;
    localparam logic [IFW_WORD_W-1:0] IFW_TWO_RESET = 16'h0000;
    localparam int IFW_TWO_SET_MAX = 8;
    localparam int IFW_TWO_SPINUP = 6;
    localparam int IFW_TWO_QUEUED = 1;
    localparam int IFW_TWO_MICROCODE = 0;

    // ------------------------------------------------------------
    // Ultra DMA mode word layout and select register fields
    // ------------------------------------------------------------
    localparam int IFW_UDMA_MODES = 5;
    localparam int IFW_UDMA_MODE_W = 3;
    localparam int IFW_UDMA_SEL_LSB = 8;
    localparam int IFW_UDMA_SUP_LSB = 0;
    localparam int IFW_SEL_MODE_LSB = 0;
    localparam int IFW_SEL_ENABLE = 3;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int IFW_ST_REJECT = 0;
    localparam int IFW_ST_SET_MAX = 1;
    localparam int IFW_ST_MODE_LSB = 4;
    localparam int IFW_ST_ACTIVE = 7;

endpackage : ifw_pkg

/* File: rtl/ifw_udma_select.sv */
// Ultra DMA mode selection state and its word fields
`timescale 1ns/10ps
module ifw_udma_select
    import ifw_pkg::*;
#(
    parameter bit UDMA_SUPPORTED = 1'b1,
    parameter int UDMA_MAX_MODE = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sel_write,
    input wire logic sel_enable,
    input wire logic [IFW_UDMA_MODE_W-1:0] sel_mode,
    output logic mode_active,
    output logic [IFW_UDMA_MODE_W-1:0] mode_current,
    output logic [IFW_UDMA_MODES-1:0] select_bits,
    output logic [IFW_UDMA_MODES-1:0] support_bits,
    output logic reject
);

    // ------------------------------------------------------------
    // Supported modes
    // ------------------------------------------------------------
    localparam logic [IFW_UDMA_MODE_W-1:0] MAX_MODE = IFW_UDMA_MODE_W'(UDMA_MAX_MODE);

    // Mode n supported implies all lower modes supported
    always_comb begin
        for (int i = 0; i < IFW_UDMA_MODES; i++) begin
            support_bits[i] = UDMA_SUPPORTED && (i <= UDMA_MAX_MODE);
        end
    end

    // ------------------------------------------------------------
    // Selection state
    // ------------------------------------------------------------
    logic next_mode_active;
    logic [IFW_UDMA_MODE_W-1:0] next_mode_current;

    // An unsupported mode is refused so the word never shows it selected
    assign reject = sel_write && sel_enable && (!UDMA_SUPPORTED || sel_mode > MAX_MODE);

    always_comb begin
        next_mode_active = mode_active;
        next_mode_current = mode_current;
        if (sel_write && !reject) begin
            next_mode_active = sel_enable;
            next_mode_current = sel_enable ? sel_mode : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_active <= 1'b0;
            mode_current <= '0;
        end else begin
            mode_active <= next_mode_active;
            mode_current <= next_mode_current;
        end
    end

    // Exactly one selected bit while a mode is active, none otherwise
    always_comb begin
        for (int i = 0; i < IFW_UDMA_MODES; i++) begin
            select_bits[i] = mode_active && (mode_current == IFW_UDMA_MODE_W'(i));
        end
    end

endmodule : ifw_udma_select

/* File: rtl/ifw_identify_words.sv */
// Identification feature words 84 to 88 with their APB register bank
//
// Operation
// - Word 85 bits 14,13,12,10,9 show NOP, buffer, protected area, reset enables.
// - Word 85 bits 8 and 7 show service and release interrupt enables.
// - Word 85 bits 6 and 5 show look-ahead and write cache enables.
// - Word 85 bit 4 always zero; obsolete bits 15 and 11 read zero.
// - Word 85 bits 3..0 show power, removable, security and SMART enables.
// - Word 86 bit 9 shows acoustic management enable; bits 15..10 reserved.
// - Word 86 bit 8 sets once set-max password extension is enabled.
// - Word 86 bit 6 set when spin-up needs a set-features subcommand.
// - Word 86 bits 5..2 show standby, status notify, advanced power, CFA.
// - Word 86 bits 1 and 0 show queued DMA and microcode support.
// - Word 88 bits 12..8 one-hot mark the selected Ultra DMA mode.
// - Word 88 bits 4..0 mark Ultra DMA modes supported, fixed.
`timescale 1ns/10ps
module ifw_identify_words
    import ifw_pkg::*;
#(
    parameter bit QUEUED_DMA_SUPPORTED = 1'b0,
    parameter bit MICROCODE_SUPPORTED = 1'b0,
    parameter bit UDMA_SUPPORTED = 1'b1,
    parameter int UDMA_MAX_MODE = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [IFW_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IFW_DATA_W-1:0] pwdata,
    input wire logic [IFW_STRB_W-1:0] pstrb,
    output logic [IFW_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spinup_cmd_required,
    input wire logic set_max_password_done,
    output logic look_ahead_enable,
    output logic write_cache_enable,
    output logic udma_active,
    output logic [IFW_UDMA_MODE_W-1:0] udma_mode
);

    // ------------------------------------------------------------
    // Address helpers
    // ------------------------------------------------------------

    // Byte address of an identification word index
    function automatic logic [IFW_ADDR_W-1:0] ifw_word_addr(
        input logic [IFW_ADDR_W-1:0] idx
    );
        ifw_word_addr = IFW_ADDR_W'(idx << IFW_IDX_SHIFT);
    endfunction : ifw_word_addr

    // Word-aligned match; the two low address bits are ignored
    function automatic logic ifw_hit(
        input logic [IFW_ADDR_W-1:0] addr,
        input logic [IFW_ADDR_W-1:0] target
    );
        ifw_hit = (addr[IFW_ADDR_W-1:IFW_IDX_SHIFT] == target[IFW_ADDR_W-1:IFW_IDX_SHIFT]);
    endfunction : ifw_hit

    // Merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [IFW_WORD_W-1:0] ifw_merge(
        input logic [IFW_WORD_W-1:0] old,
        input logic [IFW_DATA_W-1:0] wdata,
        input logic [IFW_STRB_W-1:0] strb,
        input logic [IFW_WORD_W-1:0] mask
    );
        logic [IFW_WORD_W-1:0] merged;
        merged = old;
        if (strb[0]) begin
            merged[IFW_BYTE_W-1:0] = wdata[IFW_BYTE_W-1:0];
        end
        if (strb[1]) begin
            merged[IFW_WORD_W-1:IFW_BYTE_W] = wdata[IFW_WORD_W-1:IFW_BYTE_W];
        end
        ifw_merge = merged & mask;
    endfunction : ifw_merge

    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    logic setup_phase;
    logic write_access;
    logic hit_ctrl_one;
    logic hit_ctrl_two;
    logic hit_udma_sel;
    logic hit_status;
    logic hit_ext;
    logic hit_en_one;
    logic hit_en_two;
    logic hit_default;
    logic hit_udma_word;
    logic hit_read_only;
    logic hit_any;

    // Writes land on the access edge, read data is prepared at setup
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite;

    // Decode shared by the read and write paths
    assign hit_ctrl_one = ifw_hit(paddr, IFW_ADDR_CTRL_ONE);
    assign hit_ctrl_two = ifw_hit(paddr, IFW_ADDR_CTRL_TWO);
    assign hit_udma_sel = ifw_hit(paddr, IFW_ADDR_UDMA_SEL);
    assign hit_status = ifw_hit(paddr, IFW_ADDR_STATUS);
    assign hit_ext = ifw_hit(paddr, ifw_word_addr(IFW_IDX_SUPPORT_EXT));
    assign hit_en_one = ifw_hit(paddr, ifw_word_addr(IFW_IDX_ENABLED_ONE));
    assign hit_en_two = ifw_hit(paddr, ifw_word_addr(IFW_IDX_ENABLED_TWO));
    assign hit_default = ifw_hit(paddr, ifw_word_addr(IFW_IDX_DEFAULT));
    assign hit_udma_word = ifw_hit(paddr, ifw_word_addr(IFW_IDX_UDMA_MODE));
    assign hit_read_only = hit_ext || hit_en_one || hit_en_two || hit_default
        || hit_udma_word || hit_status;
    assign hit_any = hit_read_only || hit_ctrl_one || hit_ctrl_two || hit_udma_sel;

    // Data is registered at setup, so no wait state is needed
    assign pready = 1'b1;

    // ------------------------------------------------------------
    // Feature enable state
    // ------------------------------------------------------------
    logic [IFW_WORD_W-1:0] ctrl_one;
    logic [IFW_WORD_W-1:0] ctrl_two;
    logic set_max_enabled;
    logic reject_flag;
    logic [IFW_WORD_W-1:0] next_ctrl_one;
    logic [IFW_WORD_W-1:0] next_ctrl_two;
    logic next_set_max_enabled;
    logic next_reject_flag;
    logic udma_reject;
    logic reject_clear;

    // Status bit clears on a one written to it
    assign reject_clear = write_access && hit_status && pstrb[0] && pwdata[IFW_ST_REJECT];

    // Software writes the enables; masking keeps fixed bits out of them
    always_comb begin
        next_ctrl_one = ctrl_one;
        next_ctrl_two = ctrl_two;
        if (write_access && hit_ctrl_one) begin
            next_ctrl_one = ifw_merge(ctrl_one, pwdata, pstrb, IFW_ONE_MASK);
        end
        if (write_access && hit_ctrl_two) begin
            next_ctrl_two = ifw_merge(ctrl_two, pwdata, pstrb, IFW_TWO_MASK);
        end
        // Once enabled the extension stays until the next presetn reset
        next_set_max_enabled = set_max_enabled || set_max_password_done;
        // A new refusal wins over a clear in the same cycle
        next_reject_flag = (reject_flag && !reject_clear) || udma_reject;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one <= IFW_ONE_RESET;
            ctrl_two <= IFW_TWO_RESET;
            set_max_enabled <= 1'b0;
            reject_flag <= 1'b0;
        end else begin
            ctrl_one <= next_ctrl_one;
            ctrl_two <= next_ctrl_two;
            set_max_enabled <= next_set_max_enabled;
            reject_flag <= next_reject_flag;
        end
    end

    // Enables the rest of the device acts on
    assign look_ahead_enable = ctrl_one[IFW_ONE_LOOK_AHEAD];
    assign write_cache_enable = ctrl_one[IFW_ONE_WRITE_CACHE];

    // ------------------------------------------------------------
    // Ultra DMA selection
    // ------------------------------------------------------------
    logic [IFW_UDMA_MODES-1:0] udma_select_bits;
    logic [IFW_UDMA_MODES-1:0] udma_support_bits;

    ifw_udma_select #(
        .UDMA_SUPPORTED(UDMA_SUPPORTED),
        .UDMA_MAX_MODE(UDMA_MAX_MODE)
    ) u_udma_select (
        .pclk(pclk),
        .presetn(presetn),
        .sel_write(write_access && hit_udma_sel && pstrb[0]),
        .sel_enable(pwdata[IFW_SEL_ENABLE]),
        .sel_mode(pwdata[IFW_SEL_MODE_LSB +: IFW_UDMA_MODE_W]),
        .mode_active(udma_active),
        .mode_current(udma_mode),
        .select_bits(udma_select_bits),
        .support_bits(udma_support_bits),
        .reject(udma_reject)
    );

    // ------------------------------------------------------------
    // Identification word contents
    // ------------------------------------------------------------
    logic [IFW_WORD_W-1:0] word_ext;
    logic [IFW_WORD_W-1:0] word_en_one;
    logic [IFW_WORD_W-1:0] word_en_two;
    logic [IFW_WORD_W-1:0] word_default;
    logic [IFW_WORD_W-1:0] word_udma;
    logic [IFW_WORD_W-1:0] status_word;

    // Constant words; nothing can write them
    assign word_ext = IFW_EXT_WORD_VALUE;
    assign word_default = IFW_DEFAULT_WORD_VALUE;

    // Enables pass straight through so a read sees the present state
    assign word_en_one = ctrl_one & IFW_ONE_MASK;

    // Live enables, latched extension, strap level and fixed support bits
    always_comb begin
        word_en_two = ctrl_two & IFW_TWO_MASK;
        word_en_two[IFW_TWO_SET_MAX] = set_max_enabled;
        word_en_two[IFW_TWO_SPINUP] = spinup_cmd_required;
        word_en_two[IFW_TWO_QUEUED] = QUEUED_DMA_SUPPORTED;
        word_en_two[IFW_TWO_MICROCODE] = MICROCODE_SUPPORTED;
    end

    // Selected mode on top, fixed support field below, reserved bits zero
    always_comb begin
        word_udma = '0;
        word_udma[IFW_UDMA_SEL_LSB +: IFW_UDMA_MODES] = udma_select_bits;
        word_udma[IFW_UDMA_SUP_LSB +: IFW_UDMA_MODES] = udma_support_bits;
    end

    // Software view of the block's own state
    always_comb begin
        status_word = '0;
        status_word[IFW_ST_REJECT] = reject_flag;
        status_word[IFW_ST_SET_MAX] = set_max_enabled;
        status_word[IFW_ST_MODE_LSB +: IFW_UDMA_MODE_W] = udma_mode;
        status_word[IFW_ST_ACTIVE] = udma_active;
    end

    // ------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------
    logic [IFW_DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic [IFW_WORD_W-1:0] read_word;

    // Read mux; unmapped reads return zero
    always_comb begin
        read_word = '0;
        if (hit_ext) begin
            read_word = word_ext;
        end else if (hit_en_one) begin
            read_word = word_en_one;
        end else if (hit_en_two) begin
            read_word = word_en_two;
        end else if (hit_default) begin
            read_word = word_default;
        end else if (hit_udma_word) begin
            read_word = word_udma;
        end else if (hit_ctrl_one) begin
            read_word = ctrl_one;
        end else if (hit_ctrl_two) begin
            read_word = ctrl_two;
        end else if (hit_udma_sel) begin
            read_word[IFW_SEL_MODE_LSB +: IFW_UDMA_MODE_W] = udma_mode;
            read_word[IFW_SEL_ENABLE] = udma_active;
        end else if (hit_status) begin
            read_word = status_word;
        end
    end

    // Capture at setup so the access phase sees stable registered data;
    // writes to identification words are refused with an error
    always_comb begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup_phase) begin
            next_prdata = pwrite ? '0 : {{(IFW_DATA_W-IFW_WORD_W){1'b0}}, read_word};
            next_pslverr = !hit_any || (pwrite && hit_read_only && !hit_status)
                || (pwrite && hit_udma_sel && pwdata[IFW_SEL_ENABLE]
                    && (!UDMA_SUPPORTED
                        || pwdata[IFW_SEL_MODE_LSB +: IFW_UDMA_MODE_W]
                           > IFW_UDMA_MODE_W'(UDMA_MAX_MODE)));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule : ifw_identify_words

/* File: testbench/ifw_apb_host.sv */
// Host side bus master that fetches identification words over APB
`timescale 1ns/10ps
module ifw_apb_host
    import ifw_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [IFW_DATA_W-1:0] prdata,
    output logic [IFW_ADDR_W-1:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [IFW_DATA_W-1:0] pwdata,
    output logic [IFW_STRB_W-1:0] pstrb
);
    // Idle edges after a transfer; one keeps a signal from being set twice in a step
    int unsigned idle = 1;

    // Quiet bus at time zero; the rest only matters while selected
    initial begin
        psel = 1'b0;
        penable = 1'b0;
    end

    // --------------------------------------------------------------
    // One APB transfer, entered just after a rising edge
    // --------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [IFW_ADDR_W-1:0] addr,
                        input logic [IFW_DATA_W-1:0] wdata, input logic [IFW_STRB_W-1:0] strb,
                        output logic [IFW_DATA_W-1:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count assumed; the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        // Released address and write data go inverted so stale data never passes
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
        repeat (idle) @(posedge pclk);
    endtask : xfer
endmodule : ifw_apb_host

/* File: testbench/ifw_identify_words_monitor.sv */
// Checker for the identification feature word register bank
`timescale 1ns/10ps
module ifw_identify_words_monitor
    import ifw_pkg::*;
#(
    parameter bit QUEUED_DMA_SUPPORTED = 1'b0,
    parameter bit MICROCODE_SUPPORTED = 1'b0,
    parameter int UDMA_MAX_MODE = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [IFW_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IFW_DATA_W-1:0] pwdata,
    input wire logic [IFW_STRB_W-1:0] pstrb,
    input wire logic [IFW_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic spinup_cmd_required,
    input wire logic set_max_password_done,
    input wire logic look_ahead_enable,
    input wire logic write_cache_enable,
    input wire logic udma_active,
    input wire logic [IFW_UDMA_MODE_W-1:0] udma_mode
);
    localparam logic [4:0] SUP_BITS = 5'((32'h2 << UDMA_MAX_MODE) - 1);
    logic rd_setup;
    logic seen_set_max;
    logic next_seen_set_max;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Read data is loaded at the edge closing the setup cycle
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        next_seen_set_max = seen_set_max | set_max_password_done;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_set_max <= 1'b0;
        end else begin
            seen_set_max <= next_seen_set_max;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    fixed_words_a: assert property (rd_setup && (paddr == 12'h150 || paddr == 12'h15C)
        |=> prdata == 32'h4000) else $error("word 84 or 87 wrong");
    one_zeros_a: assert property (rd_setup && paddr == 12'h154
        |=> prdata[31:16] == 16'h0 && !prdata[15] && !prdata[11] && !prdata[4])
        else $error("word 85 zero bits set");
    cache_bits_a: assert property (rd_setup && paddr == 12'h154
        |=> prdata[6:5] == {look_ahead_enable, write_cache_enable})
        else $error("word 85 cache bits");
    enable_hold_a: assert property ($changed({look_ahead_enable, write_cache_enable})
        |-> $past(psel && penable && pwrite && paddr == 12'h000)) else $error("enable moved");
    spinup_live_a: assert property (rd_setup && paddr == 12'h158 && $stable(spinup_cmd_required)
        |=> prdata[6] == $past(spinup_cmd_required)) else $error("spin-up bit wrong");
    set_max_a: assert property (rd_setup && paddr == 12'h158
        |=> prdata[8] == $past(seen_set_max)) else $error("set-max bit wrong");
    two_fixed_a: assert property (rd_setup && paddr == 12'h158
        |=> prdata[15:10] == 6'h0 && !prdata[7]
            && prdata[1:0] == {QUEUED_DMA_SUPPORTED, MICROCODE_SUPPORTED})
        else $error("word 86 fixed bits");
    udma_sel_a: assert property (rd_setup && paddr == 12'h160
        |=> prdata[12:8] == $past(udma_active ? (5'h01 << udma_mode) : 5'h00))
        else $error("selected mode bits");
    udma_sup_a: assert property (rd_setup && paddr == 12'h160
        |=> prdata[4:0] == SUP_BITS && prdata[7:5] == 3'h0 && prdata[15:13] == 3'h0)
        else $error("support bits wrong");
    udma_hold_a: assert property ($changed({udma_active, udma_mode})
        |-> $past(psel && penable && pwrite && paddr == 12'h008)) else $error("mode moved");

    active_read_c: cover property (rd_setup && paddr == 12'h160 && udma_active);
    set_max_read_c: cover property (rd_setup && paddr == 12'h158 && seen_set_max);
    refused_c: cover property (psel && penable && pslverr);
endmodule : ifw_identify_words_monitor

bind ifw_identify_words ifw_identify_words_monitor #(
    .QUEUED_DMA_SUPPORTED(QUEUED_DMA_SUPPORTED), .MICROCODE_SUPPORTED(MICROCODE_SUPPORTED),
    .UDMA_MAX_MODE(UDMA_MAX_MODE)
) u_monitor (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .spinup_cmd_required, .set_max_password_done, .look_ahead_enable,
    .write_cache_enable, .udma_active, .udma_mode
);

/* File: testbench/tb_identify_feature_words.sv */
// Self-checking bench for the identification feature word block
`timescale 1ns/10ps
module tb_identify_feature_words
    import ifw_pkg::*;
();
    localparam logic [IFW_ADDR_W-1:0] A84 = 12'h150;
    localparam logic [IFW_ADDR_W-1:0] A85 = 12'h154;
    localparam logic [IFW_ADDR_W-1:0] A86 = 12'h158;
    localparam logic [IFW_ADDR_W-1:0] A87 = 12'h15C;
    localparam logic [IFW_ADDR_W-1:0] A88 = 12'h160;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic spinup_cmd_required = 1'b0;
    logic set_max_password_done = 1'b0;
    logic [IFW_ADDR_W-1:0] paddr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [IFW_DATA_W-1:0] pwdata, prdata;
    logic [IFW_STRB_W-1:0] pstrb;
    logic look_ahead_enable, write_cache_enable, udma_active;
    logic [IFW_UDMA_MODE_W-1:0] udma_mode;
    int error_cnt = 0;
    int n_checks = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    ifw_apb_host u_host (.pclk, .pready, .pslverr, .prdata, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb);
    ifw_identify_words u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .spinup_cmd_required, .set_max_password_done,
        .look_ahead_enable, .write_cache_enable, .udma_active, .udma_mode);

    // --------------------------------------------------------------
    // Compare, access and closing tasks
    // --------------------------------------------------------------
    task automatic chk_word(input logic [IFW_DATA_W-1:0] exp, input logic [IFW_DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input logic exp, input logic got);
        chk_word(32'(exp), 32'(got));
    endtask : chk_bit
    task automatic rd(input logic [IFW_ADDR_W-1:0] a, input logic [IFW_DATA_W-1:0] exp,
                      input logic e);
        logic [IFW_DATA_W-1:0] got;
        logic err;
        u_host.xfer(1'b0, a, 32'h0, 4'h0, got, err);
        chk_word(exp, got);
        chk_bit(e, err);
    endtask : rd
    task automatic wr(input logic [IFW_ADDR_W-1:0] a, input logic [IFW_WORD_W-1:0] d,
                      input logic [IFW_STRB_W-1:0] s, input logic e);
        logic [IFW_DATA_W-1:0] got;
        logic err;
        u_host.xfer(1'b1, a, {16'h0000, d}, s, got, err);
        chk_bit(e, err);
    endtask : wr
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Watchdog: the run needs under 1000 edges
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A84, 32'h4000, 1'b0);
        rd(A87, 32'h4000, 1'b0);
        rd(A85, 32'h0, 1'b0);
        rd(A86, 32'h0, 1'b0);
        rd(A88, 32'h7, 1'b0);
        // One enable at a time shows a misplaced bit
        for (int i = 0; i < 16; i++) begin
            wr(12'h000, 16'h1 << i, 4'h3, 1'b0);
            wr(12'h004, 16'h1 << i, 4'h3, 1'b0);
            rd(A85, {16'h0, (16'h1 << i) & 16'h77EF}, 1'b0);
            rd(A86, {16'h0, (16'h1 << i) & 16'h023C}, 1'b0);
        end
        wr(12'h000, 16'h60, 4'h3, 1'b0);
        chk_bit(1'b1, look_ahead_enable);
        wr(12'h000, 16'h20, 4'h0, 1'b0);
        chk_bit(1'b1, look_ahead_enable);
        wr(12'h000, 16'h20, 4'h3, 1'b0);
        chk_bit(1'b0, look_ahead_enable);
        chk_bit(1'b1, write_cache_enable);
        // Live spin-up level, then a sticky set-max pulse
        spinup_cmd_required <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(A86, 32'h40, 1'b0);
        spinup_cmd_required <= 1'b0;
        set_max_password_done <= 1'b1;
        @(posedge pclk);
        set_max_password_done <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(A86, 32'h100, 1'b0);
        for (int m = 0; m < 3; m++) begin
            wr(12'h008, 16'h8 | 16'(m), 4'h1, 1'b0);
            rd(A88, 32'h7 | (32'h100 << m), 1'b0);
            chk_word(32'(m), 32'(udma_mode));
        end
        // Too high a mode is refused; the old choice stays
        wr(12'h008, 16'hB, 4'h1, 1'b1);
        rd(A88, 32'h407, 1'b0);
        rd(12'h00C, 32'hA3, 1'b0);
        wr(12'h00C, 16'h1, 4'h1, 1'b0);
        rd(12'h00C, 32'hA2, 1'b0);
        wr(12'h008, 16'h0, 4'h1, 1'b0);
        rd(A88, 32'h7, 1'b0);
        chk_bit(1'b0, udma_active);
        wr(A85, 16'hFFFF, 4'h3, 1'b1);
        rd(A85, 32'h20, 1'b0);
        rd(12'h200, 32'h0, 1'b1);
        // Mid-run reset clears set-max and enables
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A86, 32'h0, 1'b0);
        rd(A85, 32'h0, 1'b0);
        chk_bit(1'b0, write_cache_enable);
        give_verdict();
    end
endmodule : tb_identify_feature_words
